// *** design/wdt_pkg.sv ***
package wdt_pkg;

  typedef enum logic [2:0] {
    ST_RUN   = 3'b001,
    ST_SLEEP = 3'b010,
    ST_FIRE  = 3'b100
  } wdt_state_t;

  typedef struct packed {
    logic [7:0] psa_assign;
    logic [7:0] prescale_sel;
  } wdt_opt_t;

endpackage

// *** design/wdt_map.svh ***
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH

// control register offsets
`define WDT_ADDR_OPTION  4'h0
`define WDT_ADDR_STATUS  4'h1
`define WDT_ADDR_CTRL    4'h2
`define WDT_ADDR_COUNT   4'h3

// option fields
`define WDT_OPT_PS_LSB   0
`define WDT_OPT_PS_MSB   2
`define WDT_OPT_PSA_BIT  3
`define WDT_OPT_RESET    8'h0f

// status fields
`define WDT_ST_PD_BIT    0
`define WDT_ST_TO_BIT    1

// ctrl write fields: write-one strobes
`define WDT_CTRL_CLR_BIT   0
`define WDT_CTRL_SLEEP_BIT 1

// timing: 18 ms nominal period on the watchdog tick
`define WDT_PERIOD_US    18000
`define WDT_TICK_NS      10
`define WDT_PERIOD_CYC   ((`WDT_PERIOD_US * 1000) / `WDT_TICK_NS)

`endif

// *** design/wdt_if.sv ***
`timescale 1ns/1ps
// carries restart and expiry between the control top and the counter
interface wdt_if;
  logic       restart;
  logic       use_pre;
  logic [2:0] ps_sel;
  logic       expire;

  modport ctl (output restart, output use_pre, output ps_sel, input expire);
  modport cnt (input restart, input use_pre, input ps_sel, output expire);
endinterface : wdt_if

// *** design/wdt_sync.sv ***
`timescale 1ns/1ps
module wdt_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } sync_state_t;

  sync_state_t st_reg;
  sync_state_t st_next;

  always_comb begin
    st_next    = st_reg;
    st_next.s1 = d_i;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q_o = st_reg.s2;
endmodule : wdt_sync

// *** design/wdt_counter.sv ***
`timescale 1ns/1ps
`include "wdt_map.svh"
// base counter plus optional prescaler; runs on the watchdog's own clock
module wdt_counter #(
  parameter int PERIOD_CYC = `WDT_PERIOD_CYC
) (
  input  wire logic mclk_i,
  input  wire logic rst_i,
  wdt_if.cnt        bus
);
  localparam int CW = $clog2(PERIOD_CYC + 1);

  typedef struct packed {
    logic [CW-1:0] base;
    logic [6:0]    pre;
    logic          expire;
  } cnt_state_t;

  cnt_state_t st_reg;
  cnt_state_t st_next;

  function automatic logic [6:0] pre_limit(input logic [2:0] sel);
    pre_limit = 7'((8'h01 << sel) - 8'h01);
  endfunction

  always_comb begin
    st_next        = st_reg;
    st_next.expire = 1'b0;
    if (bus.restart) begin
      st_next.base = '0;
      st_next.pre  = '0;
    end else if (st_reg.base == CW'(PERIOD_CYC - 1)) begin // [R6]
      st_next.base = '0;
      if (!bus.use_pre || st_reg.pre >= pre_limit(bus.ps_sel)) begin
        st_next.pre    = '0;
        st_next.expire = 1'b1;
      end else begin
        st_next.pre = st_reg.pre + 7'h01;
      end
    end else begin
      st_next.base = st_reg.base + CW'(1);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign bus.expire = st_reg.expire;
endmodule : wdt_counter

// *** design/watchdog_timer_block.sv ***
`timescale 1ns/1ps
`include "wdt_map.svh"
// What this block does
// [R1] counting runs on the watchdog's own free-running clock, not the cpu clock
// [R2] counter keeps running while the cpu clock is halted in sleep
// [R3] expiry while running issues a device reset pulse
// [R4] expiry while asleep issues a wake pulse instead of reset
// [R5] fuse at zero disables the watchdog: no reset, no wake ever
// [R6] unprescaled period is nominally 18 ms
// [R7] software may assign prescaler, ratios up to 1:128
// [R8] clear-watchdog or sleep restarts counter and assigned prescaler
// [R9] every expiry clears the timeout flag
// [R10] power-down flag set at power-up and clear, cleared by sleep
// [R11] after watchdog reset or wake, counter and prescaler restart at zero
module watchdog_timer_block #(
  parameter int PERIOD_CYC = `WDT_PERIOD_CYC
) (
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic       watchdog_enable_fuse_i,
  input  wire logic       clear_watchdog_instr_i,
  input  wire logic       sleep_instr_i,
  input  wire logic       cpu_clk_halted_i,
  input  wire logic [3:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  output logic            device_reset_o,
  output logic            wake_o,
  output logic            timeout_flag_o,
  output logic            powerdown_flag_o,
  output logic            asleep_o
);
  import wdt_pkg::*;

  typedef struct packed {
    wdt_state_t  state;
    logic [7:0]  option;
    logic        timeout_flag;
    logic        powerdown_flag;
    logic        fuse;
    logic        restart;
    logic [7:0]  rdata;
    logic        dev_reset;
    logic        wake;
  } top_state_t;

  top_state_t st_reg;
  top_state_t st_next;
  wdt_if      cnt_bus ();

  logic [3:0] pins_sync;
  logic       fuse_s;
  logic       clr_s;
  logic       slp_s;
  logic       halt_s;
  logic       clr_evt;
  logic       slp_evt;
  logic       ctrl_wr;

  // fuse and cpu-side strobes arrive from another domain
  wdt_sync #(
    .WIDTH (4)
  ) u_sync (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .d_i    ({watchdog_enable_fuse_i, clear_watchdog_instr_i, sleep_instr_i,
              cpu_clk_halted_i}),
    .q_o    (pins_sync)
  );

  assign fuse_s  = pins_sync[3];
  assign clr_s   = pins_sync[2];
  assign slp_s   = pins_sync[1];
  assign halt_s  = pins_sync[0];
  assign ctrl_wr = wr_i && (addr_i == `WDT_ADDR_CTRL);
  assign clr_evt = clr_s || (ctrl_wr && wdata_i[`WDT_CTRL_CLR_BIT]);
  assign slp_evt = slp_s || (ctrl_wr && wdata_i[`WDT_CTRL_SLEEP_BIT]);

  // counter ticks every watchdog-clock edge regardless of cpu halt  [R1] [R2]
  wdt_counter #(
    .PERIOD_CYC (PERIOD_CYC)
  ) u_cnt (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .bus    (cnt_bus.cnt)
  );

  assign cnt_bus.restart = st_reg.restart;
  assign cnt_bus.use_pre = st_reg.option[`WDT_OPT_PSA_BIT]; // [R7]
  assign cnt_bus.ps_sel  = st_reg.option[`WDT_OPT_PS_MSB:`WDT_OPT_PS_LSB]; // [R7]

  always_comb begin
    st_next           = st_reg;
    st_next.dev_reset = 1'b0;
    st_next.wake      = 1'b0;
    st_next.restart   = 1'b0;
    st_next.fuse      = fuse_s;
    st_next.rdata     = 8'h00;

    if (wr_i && addr_i == `WDT_ADDR_OPTION) begin
      st_next.option = wdata_i;
    end

    if (rd_i) begin
      case (addr_i)
        `WDT_ADDR_OPTION: st_next.rdata = st_reg.option;
        `WDT_ADDR_STATUS: st_next.rdata = {6'h00, st_reg.timeout_flag, st_reg.powerdown_flag};
        `WDT_ADDR_COUNT:  st_next.rdata = {5'h00, st_reg.state};
        default:          st_next.rdata = 8'h00;
      endcase
    end

    if (clr_evt) begin
      st_next.restart        = 1'b1; // [R8]
      st_next.powerdown_flag = 1'b1; // [R10]
      st_next.timeout_flag   = 1'b1;
    end

    case (st_reg.state)
      ST_RUN: begin
        if (slp_evt) begin
          st_next.restart        = 1'b1; // [R8]
          st_next.powerdown_flag = 1'b0; // [R10]
          st_next.timeout_flag   = 1'b1;
          st_next.state          = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        // still counting here since the cpu clock may be stopped  [R2]
        if (!halt_s && !slp_evt && clr_evt) begin
          st_next.state = ST_RUN;
        end
      end
      ST_FIRE: begin
        st_next.state = ST_RUN;
      end
      default: begin
        st_next.state = ST_RUN;
      end
    endcase

    // expiry wins over a same-cycle clear: the event is never lost
    if (cnt_bus.expire && st_reg.fuse) begin // [R5]
      st_next.timeout_flag = 1'b0; // [R9]
      st_next.restart      = 1'b1; // [R11]
      if (st_reg.state == ST_SLEEP) begin
        st_next.wake  = 1'b1; // [R4]
        st_next.state = ST_RUN;
      end else begin
        st_next.dev_reset = 1'b1; // [R3]
        st_next.state     = ST_FIRE;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st_reg                <= '0;
      st_reg.state          <= ST_RUN;
      st_reg.option         <= `WDT_OPT_RESET;
      st_reg.timeout_flag   <= 1'b1;
      st_reg.powerdown_flag <= 1'b1; // [R10]
      st_reg.restart        <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata_o          = st_reg.rdata;
  assign device_reset_o   = st_reg.dev_reset;
  assign wake_o           = st_reg.wake;
  assign timeout_flag_o   = st_reg.timeout_flag;
  assign powerdown_flag_o = st_reg.powerdown_flag;
  // one-hot sleep bit, so the pin is a bare flop output
  assign asleep_o         = st_reg.state[1];
endmodule : watchdog_timer_block

// *** bench/wdt_chk.sv ***
`timescale 1ns/1ps
module wdt_chk (
  input wire logic       mclk_i,
  input wire logic       rst_i,
  input wire logic       watchdog_enable_fuse_i,
  input wire logic       clear_watchdog_instr_i,
  input wire logic       sleep_instr_i,
  input wire logic       cpu_clk_halted_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic       device_reset_o,
  input wire logic       wake_o,
  input wire logic       timeout_flag_o,
  input wire logic       powerdown_flag_o,
  input wire logic       asleep_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // fuse passes a 2-ff sync, so allow the pipe to drain
  sequence fuse_off; !watchdog_enable_fuse_i[*6]; endsequence
  sequence held_clr; clear_watchdog_instr_i[*8]; endsequence
  one_event_a: assert property (!(device_reset_o && wake_o))
    else $error("reset and wake together");
  rst_pulse_a: assert property (device_reset_o |=> !device_reset_o)
    else $error("reset pulse too long");
  rst_awake_a: assert property (device_reset_o |-> !$past(asleep_o))
    else $error("reset while asleep");
  wake_sleep_a: assert property (wake_o |-> $past(asleep_o) ##1 !wake_o)
    else $error("wake outside sleep");
  fuse_quiet_a: assert property (fuse_off |-> !device_reset_o && !wake_o)
    else $error("expiry with fuse off");
  clr_hold_a: assert property (held_clr |-> !device_reset_o)
    else $error("expiry under clear");
  to_clear_a: assert property (device_reset_o || wake_o |-> !timeout_flag_o)
    else $error("timeout flag still set");
  pd_sleep_a: assert property (sleep_instr_i |-> ##[1:4] !powerdown_flag_o)
    else $error("powerdown flag not cleared");
  pd_clr_a: assert property (clear_watchdog_instr_i && !cpu_clk_halted_i
    |-> ##[1:4] powerdown_flag_o)
    else $error("powerdown flag not set");
  rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside slot");
endmodule // wdt_chk

bind watchdog_timer_block wdt_chk chk_u (.mclk_i, .rst_i, .watchdog_enable_fuse_i,
  .clear_watchdog_instr_i, .sleep_instr_i, .cpu_clk_halted_i, .rd_i, .rdata_o,
  .device_reset_o, .wake_o, .timeout_flag_o, .powerdown_flag_o, .asleep_o);

// *** bench/watchdog_timer_block_tb.sv ***
`timescale 1ns/1ps
module watchdog_timer_block_tb;
  import wdt_pkg::*;
  localparam int P = 8;
  logic       mclk_i = 0, rst_i = 1, fuse = 1, clr = 0, slp = 0, halt = 0, wr_s = 0, rd_s = 0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic       drst, wake, to, pd, aslp;
  int         bad_count = 0, n_checks = 0, n, cnt, nrst = 0;

  watchdog_timer_block #(.PERIOD_CYC(P)) dut_u (.mclk_i(mclk_i), .rst_i(rst_i),
    .watchdog_enable_fuse_i(fuse), .clear_watchdog_instr_i(clr), .sleep_instr_i(slp),
    .cpu_clk_halted_i(halt), .addr_i(addr), .wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s),
    .rdata_o(rdata), .device_reset_o(drst), .wake_o(wake), .timeout_flag_o(to),
    .powerdown_flag_o(pd), .asleep_o(aslp));

  initial forever #5 mclk_i = ~mclk_i;
  always @(negedge mclk_i) nrst += drst;

  task chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i); wr_s <= 1; addr <= a; wdata <= d;
    @(posedge mclk_i); wr_s <= 0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge mclk_i); rd_s <= 1; addr <= a;
    @(posedge mclk_i); rd_s <= 0;
    #1 chk(rdata, e);
  endtask
  // bounded wait, so a dead counter ends as a mismatch instead of a hang
  task wait_ev(input bit w, output int k);
    k = 0;
    do begin @(posedge mclk_i); #1; k++; end while ((w ? wake : drst) !== 1'b1 && k < 3000);
  endtask
  task rng(input int k, input int lo, input int hi);
    chk(8'(k >= lo && k <= hi), 8'h01);
  endtask
  task tally_and_finish;
    if (bad_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    #300000;
    bad_count++;
    $display("CHECK FAILED %0t run timed out", $time);
    tally_and_finish;
  end

  initial begin
    repeat (6) @(posedge mclk_i);
    rst_i <= 0;
    rd(4'h0, 8'h0f);
    rd(4'h1, 8'h03);
    rd(4'h9, 8'h00);
    rd(4'h3, 8'h01);
    wr(4'h0, 8'h00);
    wait_ev(0, n);
    wait_ev(0, n);
    rng(n, P, P + 4);
    rd(4'h1, 8'h01);
    for (int s = 1; s < 8; s += 3) begin
      wr(4'h0, 8'h08 | 8'(s));
      wait_ev(0, n);
      wait_ev(0, n);
      rng(n, P << s, (P << s) + 4);
    end
    wr(4'h0, 8'h00);
    @(posedge mclk_i) clr <= 1;
    repeat (8) @(posedge mclk_i);
    cnt = nrst;
    repeat (40) @(posedge mclk_i);
    chk(8'(nrst - cnt), 8'h00);
    clr <= 0;
    rd(4'h1, 8'h03);
    @(posedge mclk_i) begin slp <= 1; halt <= 1; end
    cnt = nrst;
    @(posedge mclk_i) slp <= 0;
    wait_ev(1, n);
    rng(n, P, P + 8);
    chk(8'(nrst - cnt), 8'h00);
    chk(8'(aslp), 8'h00);
    chk({6'h00, to, pd}, 8'h00);
    rd(4'h1, 8'h00);
    halt <= 0;
    fuse <= 0;
    repeat (6) @(posedge mclk_i);
    cnt = nrst;
    repeat (100) @(posedge mclk_i);
    chk(8'(nrst - cnt), 8'h00);
    wr(4'h2, 8'h01);
    rd(4'h1, 8'h03);
    wr(4'h2, 8'h02);
    rd(4'h1, 8'h02);
    chk(8'(aslp), 8'h01);
    tally_and_finish;
  end
endmodule // watchdog_timer_block_tb
